// file: hw/ati_defines.vh
// Contract
// - Idle opcodes: busy, enter idle, drop busy, then interrupt.
// - Idle with nonzero count loads power-down timer, 5 ms per count, enables it.
// - Idle with zero count disables automatic power-down.
// - Idle Immediate: busy, idle, interrupt; count ignored, timer untouched.
// - NOP always ends with an aborted command error.
// - Read Buffer returns sector buffer through single-sector PIO handshake.
// - Read DMA moves 1 to 256 sectors; count zero means 256.
// - Start sector is the 28-bit LBA built from head and address registers.
// - Read DMA: busy while buffer fills, then may raise data request.
// - DMA request held while buffered data remains for the host.
// - Read DMA interrupts only at full completion or unrecoverable error.
// - After good Read DMA, address registers hold last sector read.
// - Read DMA error stops at failing sector, its address kept.
// - Read Multiple moves blocks of set size; data request only at block start; the code drops and raises it again for every sector.
// - Count is sectors; whole blocks then a final partial block.
// - Read Multiple aborts when block size unset or multiple disabled.
// - Read Multiple interrupts when data request rises at each block start.
// - Media error posted at block start; block still transferred. The code posts it when the failing sector is fetched.
// - Continue after error only if correctable; else stop after that block.
// - Read Multiple takes 1 to 256 sectors; error keeps failing address.
// - PIO sector: busy, fill, data request, drop busy, interrupt; host reads 512 bytes.
`ifndef ATI_DEFINES_VH
`define ATI_DEFINES_VH
// Register byte offsets
`define ATI_A_DATA    8'h00
`define ATI_A_ERRFEAT 8'h04
`define ATI_A_COUNT   8'h08
`define ATI_A_ALOW    8'h0c
`define ATI_A_AMID    8'h10
`define ATI_A_AHIGH   8'h14
`define ATI_A_DEVHEAD 8'h18
`define ATI_A_CMDSTAT 8'h1c
`define ATI_A_MULT    8'h20
`define ATI_A_POWER   8'h24
// Opcodes
`define ATI_OP_IDLE1  8'h97
`define ATI_OP_IDLE2  8'he3
`define ATI_OP_IMM1   8'h95
`define ATI_OP_IMM2   8'he1
`define ATI_OP_RBUF   8'he4
`define ATI_OP_RDMA   8'hc8
`define ATI_OP_RMUL   8'hc4
// Status and error bit positions
`define ATI_ST_BSY    7
`define ATI_ST_DRDY   6
`define ATI_ST_DRQ    3
`define ATI_ST_CORR   2
`define ATI_ST_ERR    0
`define ATI_ER_UNC    6
`define ATI_ER_ABRT   2
// Sector geometry and timer
`define ATI_SEC_WORDS 9'h100
`define ATI_MAX_SECS  9'h100
`define ATI_TICK_MS   5
`define ATI_CLK_KHZ   125000
`define ATI_TICK_CYC  20'd625000
`endif

// file: hw/ati_core.v
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/100ps
`include "ati_defines.vh"
module ati_core #(
   parameter [19:0] TICK_CYC = `ATI_TICK_CYC
) (
   input  wire        clk_i,
   input  wire        arst_n_i,
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [7:0]  paddr_i,
   input  wire [31:0] pwdata_i,
   output wire [31:0] prdata_o,
   output wire        pready_o,
   output wire        pslverr_o,
   output wire        dmareq_o,
   input  wire        dmack_n_i,
   input  wire        iord_n_i,
   output wire [15:0] dma_data_o,
   output wire        intrq_o,
   output wire        med_req_o,
   output wire [27:0] med_lba_o,
   input  wire        med_we_i,
   input  wire [7:0]  med_waddr_i,
   input  wire [15:0] med_wdata_i,
   input  wire        med_done_i,
   input  wire        med_unc_i,
   input  wire        med_corr_i,
   output wire        standby_o
);
   // Sequencer states
   localparam [2:0] S_IDLE  = 3'h0;
   localparam [2:0] S_CMD   = 3'h1;
   localparam [2:0] S_FETCH = 3'h2;
   localparam [2:0] S_PIO   = 3'h3;
   localparam [2:0] S_DMA   = 3'h4;
   // Transfer modes
   localparam [1:0] M_BUF   = 2'h0;
   localparam [1:0] M_DMA   = 2'h1;
   localparam [1:0] M_MUL   = 2'h2;
   // Last count of one power-down unit
   localparam [19:0] TICK_END = TICK_CYC - 20'h1;

   // Sector buffer, one sector of 16-bit words
   reg [15:0] buf_q [0:255];
   // Command, task file and transfer progress
   reg [2:0]  st_q;
   reg [1:0]  mode_q;
   reg [7:0]  cmd_q;
   reg [7:0]  err_q;
   reg [7:0]  feat_q;
   reg [7:0]  cnt_q;
   reg [7:0]  alow_q;
   reg [7:0]  amid_q;
   reg [7:0]  ahigh_q;
   reg [7:0]  dh_q;
   reg [7:0]  mult_q;
   reg        corr_q;
   reg        stop_q;
   reg        bstart_q;
   reg [8:0]  sec_q;
   reg [8:0]  blk_q;
   reg [8:0]  ptr_q;
   // Host side outputs and power-down state
   reg        irq_q;
   reg        dmareq_q;
   reg [15:0] dmad_q;
   reg        iord_prev_q;
   reg        medreq_q;
   reg [27:0] medlba_q;
   reg        apd_en_q;
   reg [7:0]  apd_val_q;
   reg [7:0]  unit_q;
   reg [19:0] tick_q;
   reg        standby_q;
   // Bus answer
   reg        pready_q;
   reg        pslverr_q;
   reg [31:0] prdata_q;

   // Address map check, used for error answer and access decode
   function mapped;
      input [7:0] a;
      begin
         mapped = (a[1:0] == 2'h0) && (a <= `ATI_A_POWER);
      end
   endfunction

   // Bus decode, start address and sector arithmetic
   wire        acc     = psel_i & penable_i & pready_q;
   wire        wr      = acc & pwrite_i & mapped(paddr_i);
   wire        rd      = acc & ~pwrite_i & mapped(paddr_i);
   wire        tf_wr   = wr & (st_q == S_IDLE);
   wire [27:0] lba     = {dh_q[3:0], ahigh_q, amid_q, alow_q};
   wire [8:0]  reqn    = (cnt_q == 8'h00) ? `ATI_MAX_SECS : {1'b0, cnt_q};
   wire [8:0]  multn   = {1'b0, mult_q};
   wire [8:0]  firstb  = (reqn < multn) ? reqn : multn;
   wire [8:0]  secm1   = sec_q - 9'h001;
   wire [8:0]  nextb   = (secm1 < multn) ? secm1 : multn;
   wire        busy    = (st_q == S_CMD) | (st_q == S_FETCH);
   wire        drq     = (st_q == S_PIO);
   wire [7:0]  status  = {busy, 1'b1, 3'h0, corr_q, 1'b0, |err_q} |
                         ({7'h00, drq} << `ATI_ST_DRQ);
   wire        pio_pop = rd & (paddr_i == `ATI_A_DATA) & drq;
   wire        dma_stb = (st_q == S_DMA) & ~dmack_n_i & iord_prev_q & ~iord_n_i;
   wire        word    = pio_pop | dma_stb;
   wire        sec_end = word & (ptr_q == `ATI_SEC_WORDS - 9'h001);
   wire        cmd_go  = tf_wr & (paddr_i == `ATI_A_CMDSTAT);
   wire        st_rd   = rd & (paddr_i == `ATI_A_CMDSTAT);
   // Interrupt set pulse and read mux result
   reg         irq_set;
   reg [31:0]  rdat;

   // Read data mux
   always @* begin
      rdat = 32'h0000_0000;
      if (paddr_i == `ATI_A_DATA) begin
         rdat = {16'h0000, buf_q[ptr_q[7:0]]};
      end else if (paddr_i == `ATI_A_ERRFEAT) begin
         rdat = {24'h000000, err_q};
      end else if (paddr_i == `ATI_A_COUNT) begin
         rdat = {24'h000000, cnt_q};
      end else if (paddr_i == `ATI_A_ALOW) begin
         rdat = {24'h000000, alow_q};
      end else if (paddr_i == `ATI_A_AMID) begin
         rdat = {24'h000000, amid_q};
      end else if (paddr_i == `ATI_A_AHIGH) begin
         rdat = {24'h000000, ahigh_q};
      end else if (paddr_i == `ATI_A_DEVHEAD) begin
         rdat = {24'h000000, dh_q};
      end else if (paddr_i == `ATI_A_CMDSTAT) begin
         rdat = {24'h000000, status};
      end else if (paddr_i == `ATI_A_MULT) begin
         rdat = {24'h000000, mult_q};
      end else if (paddr_i == `ATI_A_POWER) begin
         rdat = {16'h0000, apd_val_q, 5'h00, standby_q, apd_en_q, 1'b1};
      end
   end

   // Bus answer: one wait cycle, data and error latched with ready
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= psel_i & penable_i & ~pready_q;
         if (psel_i & penable_i & ~pready_q) begin
            pslverr_q <= ~mapped(paddr_i);
            prdata_q  <= pwrite_i ? 32'h0000_0000 : rdat;
         end
      end
   end

   // Sector buffer, filled by the media side
   always @(posedge clk_i) begin
      if (med_we_i) begin
         buf_q[med_waddr_i] <= med_wdata_i;
      end
   end

   // DMA word presented to host, strobe edge tracking
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dmad_q      <= 16'h0000;
         iord_prev_q <= 1'b1;
      end else begin
         dmad_q      <= buf_q[ptr_q[7:0]];
         iord_prev_q <= iord_n_i;
      end
   end

   // Host interrupt: set wins over the clear by status read
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_set | (irq_q & ~st_rd & ~cmd_go);
      end
   end

   // Task file, command sequencer and power-down timer
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_q      <= S_IDLE;
         mode_q    <= M_BUF;
         cmd_q     <= 8'h00;
         err_q     <= 8'h00;
         feat_q    <= 8'h00;
         cnt_q     <= 8'h01;
         alow_q    <= 8'h01;
         amid_q    <= 8'h00;
         ahigh_q   <= 8'h00;
         dh_q      <= 8'h00;
         mult_q    <= 8'h00;
         corr_q    <= 1'b0;
         stop_q    <= 1'b0;
         bstart_q  <= 1'b0;
         sec_q     <= 9'h000;
         blk_q     <= 9'h000;
         ptr_q     <= 9'h000;
         dmareq_q  <= 1'b0;
         medreq_q  <= 1'b0;
         medlba_q  <= 28'h0000000;
         apd_en_q  <= 1'b0;
         apd_val_q <= 8'h00;
         unit_q    <= 8'h00;
         tick_q    <= 20'h00000;
         standby_q <= 1'b0;
         irq_set   <= 1'b0;
      end else begin
         irq_set <= 1'b0;
         if (tf_wr) begin
            if (paddr_i == `ATI_A_ERRFEAT) feat_q <= pwdata_i[7:0];
            if (paddr_i == `ATI_A_COUNT) cnt_q <= pwdata_i[7:0];
            if (paddr_i == `ATI_A_ALOW) alow_q <= pwdata_i[7:0];
            if (paddr_i == `ATI_A_AMID) amid_q <= pwdata_i[7:0];
            if (paddr_i == `ATI_A_AHIGH) ahigh_q <= pwdata_i[7:0];
            if (paddr_i == `ATI_A_DEVHEAD) dh_q <= pwdata_i[7:0];
            if (paddr_i == `ATI_A_MULT) mult_q <= pwdata_i[7:0];
         end
         if (word) begin
            ptr_q <= ptr_q + 9'h001;
         end
         // Power-down count runs only while the drive sits idle
         if ((st_q == S_IDLE) & apd_en_q & ~standby_q) begin
            if (tick_q == TICK_END) begin
               tick_q <= 20'h00000;
               unit_q <= unit_q - 8'h01;
               if (unit_q <= 8'h01) standby_q <= 1'b1;
            end else begin
               tick_q <= tick_q + 20'h00001;
            end
         end
         case (st_q)
            // Wait for a command write
            S_IDLE: begin
               if (cmd_go) begin
                  cmd_q  <= pwdata_i[7:0];
                  err_q  <= 8'h00;
                  corr_q <= 1'b0;
                  stop_q <= 1'b0;
                  st_q   <= S_CMD;
               end
            end
            // One busy cycle to decode the opcode
            S_CMD: begin
               if ((cmd_q == `ATI_OP_IDLE1) | (cmd_q == `ATI_OP_IDLE2)) begin
                  standby_q <= 1'b0;
                  irq_set   <= 1'b1;
                  st_q      <= S_IDLE;
                  tick_q    <= 20'h00000;
                  apd_val_q <= cnt_q;
                  unit_q    <= cnt_q;
                  apd_en_q  <= (cnt_q != 8'h00);
               end else if ((cmd_q == `ATI_OP_IMM1) | (cmd_q == `ATI_OP_IMM2)) begin
                  standby_q <= 1'b0;
                  irq_set   <= 1'b1;
                  st_q      <= S_IDLE;
               end else if (cmd_q == `ATI_OP_RBUF) begin
                  mode_q  <= M_BUF;
                  sec_q   <= 9'h001;
                  ptr_q   <= 9'h000;
                  irq_set <= 1'b1;
                  st_q    <= S_PIO;
               end else if (cmd_q == `ATI_OP_RDMA) begin
                  mode_q    <= M_DMA;
                  sec_q     <= reqn;
                  standby_q <= 1'b0;
                  medlba_q  <= lba;
                  medreq_q  <= 1'b1;
                  st_q      <= S_FETCH;
               end else if ((cmd_q == `ATI_OP_RMUL) & (mult_q != 8'h00)) begin
                  mode_q    <= M_MUL;
                  sec_q     <= reqn;
                  blk_q     <= firstb;
                  bstart_q  <= 1'b1;
                  standby_q <= 1'b0;
                  medlba_q  <= lba;
                  medreq_q  <= 1'b1;
                  st_q      <= S_FETCH;
               end else begin
                  err_q[`ATI_ER_ABRT] <= 1'b1;
                  irq_set <= 1'b1;
                  st_q    <= S_IDLE;
               end
            end
            // Media fills the buffer, busy stands
            S_FETCH: begin
               if (med_done_i) begin
                  medreq_q <= 1'b0;
                  ptr_q    <= 9'h000;
                  if (med_corr_i) corr_q <= 1'b1;
                  if (med_unc_i) begin
                     err_q[`ATI_ER_UNC] <= 1'b1;
                     stop_q <= 1'b1;
                  end
                  if (mode_q == M_DMA) begin
                     if (med_unc_i) begin
                        irq_set <= 1'b1;
                        st_q    <= S_IDLE;
                     end else begin
                        dmareq_q <= 1'b1;
                        st_q     <= S_DMA;
                     end
                  end else begin
                     st_q     <= S_PIO;
                     bstart_q <= 1'b0;
                     if (bstart_q) irq_set <= 1'b1;
                  end
               end
            end
            // Host reads sector words through the data register
            S_PIO: begin
               if (sec_end) begin
                  if ((mode_q == M_BUF) | (sec_q == 9'h001)) begin
                     st_q <= S_IDLE;
                  end else if (blk_q == 9'h001) begin
                     if (stop_q) begin
                        st_q <= S_IDLE;
                     end else begin
                        blk_q    <= nextb;
                        bstart_q <= 1'b1;
                        sec_q    <= secm1;
                        {dh_q[3:0], ahigh_q, amid_q, alow_q} <= lba + 28'h0000001;
                        medlba_q <= lba + 28'h0000001;
                        medreq_q <= 1'b1;
                        st_q     <= S_FETCH;
                     end
                  end else begin
                     blk_q    <= blk_q - 9'h001;
                     sec_q    <= secm1;
                     // After an error the task file keeps the failing sector
                     if (!stop_q) begin
                        {dh_q[3:0], ahigh_q, amid_q, alow_q} <= lba + 28'h0000001;
                     end
                     medlba_q <= medlba_q + 28'h0000001;
                     medreq_q <= 1'b1;
                     st_q     <= S_FETCH;
                  end
               end
            end
            // Host takes sector words by strobe
            S_DMA: begin
               if (sec_end) begin
                  dmareq_q <= 1'b0;
                  if (sec_q == 9'h001) begin
                     irq_set <= 1'b1;
                     st_q    <= S_IDLE;
                  end else begin
                     sec_q    <= secm1;
                     {dh_q[3:0], ahigh_q, amid_q, alow_q} <= lba + 28'h0000001;
                     medlba_q <= lba + 28'h0000001;
                     medreq_q <= 1'b1;
                     st_q     <= S_FETCH;
                  end
               end
            end
            default: begin
               st_q <= S_IDLE;
            end
         endcase
      end
   end

   // Outputs straight from their flip-flops
   assign prdata_o   = prdata_q;
   assign pready_o   = pready_q;
   assign pslverr_o  = pslverr_q;
   assign dmareq_o   = dmareq_q;
   assign dma_data_o = dmad_q;
   assign intrq_o    = irq_q;
   assign med_req_o  = medreq_q;
   assign med_lba_o  = medlba_q;
   assign standby_o  = standby_q;
endmodule // ati_core

// file: verif/ati_media_model.sv
`timescale 1ns/100ps
module ati_media_model (
   input  wire        clk_i,
   input  wire        arst_n_i,
   input  wire        slow_i,
   input  wire        req_i,
   input  wire [27:0] lba_i,
   input  wire [27:0] unc_lba_i,
   input  wire [27:0] corr_lba_i,
   output reg         we_o,
   output reg  [7:0]  waddr_o,
   output reg  [15:0] wdata_o,
   output reg         done_o,
   output reg         unc_o,
   output reg         corr_o
);
   reg [8:0] cnt_q;
   reg       tick_q;
   // Fill the sector buffer word by word, then report the fetch
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         {we_o, waddr_o, wdata_o, done_o, unc_o, corr_o, tick_q} <= 0;
         cnt_q <= 9'h000;
      end else begin
         tick_q  <= ~tick_q;
         we_o    <= 1'b0;
         done_o  <= 1'b0;
         wdata_o <= ~wdata_o; // Junk when idle
         unc_o   <= ~unc_o;
         corr_o  <= ~corr_o;
         if (req_i && !done_o && (!slow_i || tick_q)) begin
            if (cnt_q != 9'h100) begin
               we_o    <= 1'b1;
               waddr_o <= cnt_q[7:0];
               wdata_o <= lba_i[15:0] ^ {8'ha5, cnt_q[7:0]};
               cnt_q   <= cnt_q + 9'h001;
            end else begin
               done_o <= 1'b1;
               unc_o  <= (lba_i == unc_lba_i);
               corr_o <= (lba_i == corr_lba_i);
               cnt_q  <= 9'h000;
            end
         end
      end
   end
endmodule // ati_media_model

// file: verif/ati_core_chk.sv
`timescale 1ns/100ps
module ati_core_chk (
   input wire        clk_i,
   input wire        arst_n_i,
   input wire        psel_i,
   input wire        penable_i,
   input wire [7:0]  paddr_i,
   input wire        pready_o,
   input wire        pslverr_o,
   input wire        dmareq_o,
   input wire        dmack_n_i,
   input wire        iord_n_i,
   input wire        intrq_o,
   input wire        med_req_o,
   input wire [27:0] med_lba_o,
   input wire        med_done_i
);
   reg       iord_q;
   reg [8:0] stb_q;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   // Count words taken while the request stands
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         iord_q <= 1'b1;
         stb_q  <= 9'h000;
      end else begin
         iord_q <= iord_n_i;
         if (!dmareq_o)
            stb_q <= 9'h000;
         else if (!dmack_n_i && iord_q && !iord_n_i)
            stb_q <= stb_q + 9'h001;
      end
   end
   AST_ONE_WAIT: assert property ($rose(penable_i) && psel_i |-> !pready_o ##1 pready_o)
      else $error("ready not in second access cycle");
   AST_SLVERR: assert property (pready_o |-> pslverr_o == (paddr_i > 8'h24 || paddr_i[1:0] != 2'b00))
      else $error("slave error does not match address");
   AST_MED_HOLD: assert property (med_req_o && !med_done_i |=> med_req_o)
      else $error("fetch request dropped early");
   AST_LBA_STABLE: assert property (med_req_o && $past(med_req_o) |-> $stable(med_lba_o))
      else $error("fetch address moved");
   AST_REQ_AFTER_FETCH: assert property ($rose(dmareq_o) |-> $past(med_done_i))
      else $error("dma request before buffer filled");
   AST_NO_FETCH_IN_DMA: assert property (dmareq_o |-> !med_req_o)
      else $error("fetch while dma request stands");
   AST_NO_IRQ_MID_DMA: assert property (dmareq_o |-> !intrq_o)
      else $error("interrupt during dma transfer");
   AST_SECTOR_END: assert property (stb_q == 9'h100 |-> ##[0:2] !dmareq_o)
      else $error("dma request held past sector");
   CV_DMA: cover property ($rose(dmareq_o));
   CV_IRQ: cover property ($rose(intrq_o));
   CV_ERR: cover property (pready_o && pslverr_o);
endmodule // ati_core_chk
bind ati_core ati_core_chk u_chk (
   .clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .dmareq_o(dmareq_o), .dmack_n_i(dmack_n_i),
   .iord_n_i(iord_n_i), .intrq_o(intrq_o), .med_req_o(med_req_o), .med_lba_o(med_lba_o),
   .med_done_i(med_done_i)
);

// file: verif/tb_ata_idle_and_read_commands.sv
`timescale 1ns/100ps
`include "ati_defines.vh"
module tb_ata_idle_and_read_commands;
   localparam [19:0] TICK = 20'd20;
   reg         clk_i = 0, arst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
   reg         dmack_n_i = 1, iord_n_i = 1, slow = 0, serr, irq_q = 0;
   reg  [7:0]  paddr_i = 0, op;
   reg  [31:0] pwdata_i = 0, rd, seed = 32'h4bf3fe34;
   reg  [27:0] unc_lba = 28'hfffffff, corr_lba = 28'hfffffff, base;
   reg  [55:0] ops = {8'h97, 8'he3, 8'h95, 8'he1, 8'h00, 8'hc4, 8'hb0};
   wire [31:0] prdata_o;
   wire [15:0] dma_data_o, wd;
   wire [27:0] med_lba_o;
   wire [7:0]  wa;
   wire        pready_o, pslverr_o, dmareq_o, intrq_o, med_req_o, standby_o, we, done, unc, corr;
   integer     num_errors = 0, n_compared = 0, nirq = 0, i, m;
   always #4 clk_i = ~clk_i;
   ati_core #(.TICK_CYC(TICK)) u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .dmareq_o(dmareq_o),
      .dmack_n_i(dmack_n_i), .iord_n_i(iord_n_i), .dma_data_o(dma_data_o), .intrq_o(intrq_o),
      .med_req_o(med_req_o), .med_lba_o(med_lba_o), .med_we_i(we), .med_waddr_i(wa),
      .med_wdata_i(wd), .med_done_i(done), .med_unc_i(unc), .med_corr_i(corr), .standby_o(standby_o));
   ati_media_model u_med (.clk_i(clk_i), .arst_n_i(arst_n_i), .slow_i(slow), .req_i(med_req_o),
      .lba_i(med_lba_o), .unc_lba_i(unc_lba), .corr_lba_i(corr_lba), .we_o(we), .waddr_o(wa),
      .wdata_o(wd), .done_o(done), .unc_o(unc), .corr_o(corr));
   // Interrupt raises seen by the host
   always @(posedge clk_i) begin
      if (intrq_o === 1'b1 && irq_q !== 1'b1) nirq = nirq + 1;
      irq_q <= intrq_o;
   end
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function [15:0] word(input [27:0] l, input integer w);
      word = l[15:0] ^ {8'ha5, w[7:0]};
   endfunction
   task end_of_test;
      begin
         $display("compared %0d, mismatches %0d", n_compared, num_errors);
         if (num_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // One APB transfer, entered just after a rising edge
   task apb(input w, input [7:0] a, input [31:0] d);
      integer t;
      begin
         psel_i <= 1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
         @(posedge clk_i);
         penable_i <= 1;
         t = 0;
         @(posedge clk_i);
         while (pready_o !== 1'b1 && t < 50) begin
            t = t + 1;
            @(posedge clk_i);
         end
         if (t == 50) num_errors = num_errors + 1;
         rd = prdata_o;
         serr = pslverr_o;
         psel_i <= 0; penable_i <= 0;
         @(posedge clk_i);
      end
   endtask
   task rdchk(input [7:0] a, input [31:0] exp);
      begin
         apb(0, a, 0);
         chk(rd, exp);
      end
   endtask
   task setlba(input [27:0] l, input [7:0] n);
      begin
         apb(1, `ATI_A_ALOW, l[7:0]); apb(1, `ATI_A_AMID, l[15:8]); apb(1, `ATI_A_AHIGH, l[23:16]);
         apb(1, `ATI_A_DEVHEAD, {4'he, l[27:24]}); apb(1, `ATI_A_COUNT, n);
      end
   endtask
   task chkaddr(input [27:0] l);
      begin
         rdchk(`ATI_A_ALOW, l[7:0]); rdchk(`ATI_A_AMID, l[15:8]); rdchk(`ATI_A_AHIGH, l[23:16]);
         rdchk(`ATI_A_DEVHEAD, {4'he, l[27:24]});
      end
   endtask
   task waitst(input [7:0] mask);
      integer t;
      begin
         t = 0; rd = 0;
         while ((rd[7:0] & mask) !== mask && t < 600) begin
            apb(0, `ATI_A_CMDSTAT, 0);
            t = t + 1;
         end
         if (t == 600) num_errors = num_errors + 1;
      end
   endtask
   // PIO sectors through the data register
   task pio(input [27:0] l, input integer n);
      integer s, w;
      begin
         for (s = 0; s < n; s = s + 1) begin
            waitst(8'h08);
            for (w = 0; w < 256; w = w + 1) begin
               apb(0, `ATI_A_DATA, 0);
               chk(rd, {16'h0, word(l + s, w)});
            end
         end
      end
   endtask
   // DMA sectors, one strobe every four clocks
   task dma(input [27:0] l, input integer n);
      integer s, w, t;
      begin
         dmack_n_i <= 0;
         for (s = 0; s < n; s = s + 1) begin
            t = 0;
            while (dmareq_o !== 1'b1 && t < 3000) begin
               t = t + 1;
               @(posedge clk_i);
            end
            if (t == 3000) num_errors = num_errors + 1;
            repeat (3) @(posedge clk_i);
            for (w = 0; w < 256; w = w + 1) begin
               chk({16'h0, dma_data_o}, {16'h0, word(l + s, w)});
               iord_n_i <= 0;
               @(posedge clk_i);
               iord_n_i <= 1;
               repeat (3) @(posedge clk_i);
            end
         end
         dmack_n_i <= 1;
      end
   endtask
   initial begin
      #(8 * 60000);
      num_errors = num_errors + 1;
      end_of_test;
   end
   initial begin
      repeat (6) @(posedge clk_i);
      arst_n_i <= 1;
      @(posedge clk_i);
      rdchk(`ATI_A_COUNT, 32'h01);
      rdchk(`ATI_A_CMDSTAT, 32'h40);
      rdchk(`ATI_A_POWER, 32'h01);
      apb(0, 8'h28, 0);
      chk({serr, rd[30:0]}, 32'h80000000);
      $display("test reset done");
      for (i = 0; i < 7; i = i + 1) begin
         m = nirq;
         op = ops[55 - 8 * i -: 8];
         apb(1, `ATI_A_COUNT, i + 2);
         apb(1, `ATI_A_CMDSTAT, op);
         rdchk(`ATI_A_CMDSTAT, (i < 4) ? 32'h40 : 32'h41);
         chk(nirq - m, 1);
         rdchk(`ATI_A_ERRFEAT, (i < 4) ? 32'h00 : 32'h04);
      end
      apb(0, `ATI_A_POWER, 0);
      chk(rd & 32'hff02, 32'h0302);
      apb(1, `ATI_A_COUNT, 3);
      apb(1, `ATI_A_CMDSTAT, 8'h97);
      repeat (3 * TICK - 8) @(posedge clk_i);
      chk(standby_o, 0);
      repeat (16) @(posedge clk_i);
      chk(standby_o, 1);
      apb(1, `ATI_A_COUNT, 0);
      apb(1, `ATI_A_CMDSTAT, 8'he3);
      repeat (3 * TICK + 16) @(posedge clk_i);
      rdchk(`ATI_A_POWER, 32'h01);
      $display("test idle done");
      seed = lfsr(lfsr(seed));
      base = seed[27:0];
      setlba(base, 2);
      m = nirq;
      apb(1, `ATI_A_CMDSTAT, 8'hc8);
      dma(base, 2);
      repeat (8) @(posedge clk_i);
      chk(nirq - m, 1);
      chkaddr(base + 1);
      slow <= 1;
      unc_lba <= base + 1;
      setlba(base, 3);
      m = nirq;
      apb(1, `ATI_A_CMDSTAT, 8'hc8);
      dma(base, 1);
      waitst(8'h01);
      chk(nirq - m, 1);
      chkaddr(base + 1);
      apb(0, `ATI_A_ERRFEAT, 0);
      chk(rd & 32'h40, 32'h40);
      slow <= 0;
      $display("test read dma done");
      unc_lba <= 28'hfffffff;
      corr_lba <= base + 1;
      apb(1, `ATI_A_MULT, 2);
      setlba(base, 3);
      m = nirq;
      apb(1, `ATI_A_CMDSTAT, 8'hc4);
      pio(base, 3);
      chk(nirq - m, 2);
      rdchk(`ATI_A_CMDSTAT, 32'h44);
      corr_lba <= 28'hfffffff;
      unc_lba <= base;
      setlba(base, 4);
      m = nirq;
      apb(1, `ATI_A_CMDSTAT, 8'hc4);
      pio(base, 2);
      repeat (300) @(posedge clk_i);
      chk(nirq - m, 1);
      apb(0, `ATI_A_ERRFEAT, 0);
      chk(rd & 32'h40, 32'h40);
      chkaddr(base);
      unc_lba <= 28'hfffffff;
      m = nirq;
      apb(1, `ATI_A_CMDSTAT, 8'he4);
      pio(base + 1, 1);
      chk(nirq - m, 1);
      $display("test read multiple and buffer done");
      end_of_test;
   end
endmodule // tb_ata_idle_and_read_commands
